// ### common/port_mode_map.vh
// Register offsets, field positions, reset values and mode codes for the port drive mode block.
`ifndef PORT_MODE_MAP_VH
`define PORT_MODE_MAP_VH
`define PMS_INDEX          8'hC1
`define PMS_BYTE_ADDR      10'h304
`define PMS_RESET          8'h03
`define PMS_RESET_TRI      8'h55
`define MODE_QUASI         2'h0
`define MODE_PUSH_PULL     2'h2
`define MODE_INPUT_ONLY    2'h1
`define MODE_OPEN_DRAIN    2'h3
`define STRONG_PULSE_NS    20
`define CLK_PERIOD_NS      20
`define STRONG_PULSE_CYC   ((`STRONG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWD_KEEP_P3        8'h0C
`define PWD_KEEP_AUX       8'hC0
`endif

// ### src/pin_driver.v
// Output driver control for one 8-bit port in one of four drive modes.
`timescale 1ns/100ps
`include "port_mode_map.vh"
module pin_driver (
  input  wire       clk_sys_i,
  input  wire       reset_i,
  input  wire [1:0] mode_i,
  input  wire [7:0] latch_i,
  input  wire [7:0] pin_sync_i,
  input  wire [7:0] keep_in_i,
  input  wire       power_down_i,
  output reg  [7:0] pull_down_o,
  output reg  [7:0] strong_up_o,
  output reg  [7:0] weak_up_o,
  output reg  [7:0] very_weak_up_o,
  output reg  [7:0] in_enable_o
);

  reg [7:0] latch_prev_reg;
  reg [7:0] pd_next;
  reg [7:0] su_next;
  reg [7:0] wu_next;
  reg [7:0] vw_next;
  wire [7:0] rise;

  // Latch history for 0-to-1 detection; reset to ones so no pulse follows reset.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      latch_prev_reg <= 8'hFF;
    end else begin
      latch_prev_reg <= latch_i;
    end
  end

  assign rise = latch_i & ~latch_prev_reg;

  // Decode the drive mode into the four transistor enables.
  always @* begin
    pd_next = 8'h00;
    su_next = 8'h00;
    wu_next = 8'h00;
    vw_next = 8'h00;
    case (mode_i)
      `MODE_QUASI: begin
        pd_next = ~latch_i;
        vw_next = latch_i;
        wu_next = latch_i & pin_sync_i;
        su_next = rise;
      end
      `MODE_PUSH_PULL: begin
        pd_next = ~latch_i;
        su_next = latch_i;
      end
      `MODE_OPEN_DRAIN: begin
        pd_next = ~latch_i;
      end
      default: begin
        pd_next = 8'h00;
      end
    endcase
  end

  // Registered enables; the quasi-mode strong pull-up therefore lasts exactly one clock.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      pull_down_o    <= 8'h00;
      strong_up_o    <= 8'h00;
      weak_up_o      <= 8'h00;
      very_weak_up_o <= 8'h00;
      in_enable_o    <= 8'hFF;
    end else begin
      pull_down_o    <= pd_next;
      strong_up_o    <= su_next;
      weak_up_o      <= wu_next;
      very_weak_up_o <= vw_next;
      in_enable_o    <= power_down_i ? keep_in_i : 8'hFF;
    end
  end

endmodule // pin_driver

// ### src/mode_reg_ahb.v
// AHB-Lite slave holding the port drive mode select register.
`timescale 1ns/100ps
`include "port_mode_map.vh"
module mode_reg_ahb (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        tristate_fuse_i,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [7:0]  mode_reg
);

  reg        fuse_reg;
  reg        wr_pend_reg;
  reg        rst_seen_reg;
  wire       hit;

  // Every access completes in its first data phase cycle with OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hit = hsel && hready && htrans[1] && (haddr[9:2] == `PMS_INDEX) && (haddr[31:10] == 22'h0);

  // Fuse level is sampled by a clocked process, never loaded under reset directly.
  always @(posedge clk_sys_i) begin
    fuse_reg <= tristate_fuse_i;
  end

  // Register write on the data phase; reset default follows the fuse one cycle after release.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_pend_reg  <= 1'b0;
      rst_seen_reg <= 1'b1;
      mode_reg     <= `PMS_RESET;
      hrdata       <= 32'h0;
    end else begin
      rst_seen_reg <= 1'b0;
      wr_pend_reg  <= hit && hwrite;
      if (rst_seen_reg && fuse_reg) begin
        mode_reg <= `PMS_RESET_TRI;
      end else if (wr_pend_reg) begin
        mode_reg <= hwdata[7:0];
      end
      // A read right behind a write returns the low byte being written, so back-to-back access stays coherent.
      hrdata <= (hit && !hwrite) ? {24'h0, (wr_pend_reg ? hwdata[7:0] : mode_reg)} : 32'h0;
    end
  end

endmodule // mode_reg_ahb

// ### src/port_mode_ctrl.v
// Top of the per-port drive mode and pull-up control for four ports and the auxiliary port.
//
// Behaviour
// - Software picks one of four drive modes per 8-bit port 0-3 and all its pins follow it.
// - Mode pairs low,high decode 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - Port n low mode bit sits at bit 2n and high mode bit at bit 2n+1 of one 8-bit register.
// - With the tristate fuse enabled every pin of ports 0-3 is input-only after reset.
// - With the fuse disabled ports 1-3 are quasi and port 0 open-drain, register value 03h.
// - The auxiliary port is always quasi-bidirectional regardless of register or fuse.
// - In power-down all input buffers are off except two irq pins and two osc pins.
// - Quasi mode drives a strong low whenever the latch holds 0.
// - Quasi mode drives high only weakly outside the one-clock strong pulse, so external circuits can pull the pin low.
// - Quasi mode enables the very weak pull-up whenever the latch holds 1.
// - Quasi mode enables the weak pull-up only while latch and pin both read 1.
// - Quasi mode enables the strong pull-up for exactly one clock after a latch 0-to-1 change.
// - Input-only mode tristates all output drivers.
// - Open-drain mode has no pull-ups and pulls down only while the latch holds 0.
// - Push-pull mode pulls low on 0 and holds a continuous strong pull-up on 1.
`timescale 1ns/100ps
`include "port_mode_map.vh"
module port_mode_ctrl #(
  parameter NUM_PORTS = 5
) (
  input  wire        clk_sys_i,
  input  wire        reset_i,
  input  wire        tristate_fuse_i,
  input  wire        power_down_i,
  input  wire [39:0] port_latch_i,
  input  wire [39:0] pin_level_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output wire [39:0] pull_down_o,
  output wire [39:0] strong_up_o,
  output wire [39:0] weak_up_o,
  output wire [39:0] very_weak_up_o,
  output wire [39:0] in_enable_o
);

  wire [7:0]  mode_reg;
  reg  [39:0] pin_meta_reg;
  reg  [39:0] pin_sync_reg;

  // Pin levels arrive from outside and pass two flip-flops before the pull-up logic.
  always @(posedge clk_sys_i) begin
    pin_meta_reg <= pin_level_i;
    pin_sync_reg <= pin_meta_reg;
  end

  // Returns the two-bit mode of one port, low bit at 2n and high bit at 2n+1.
  function [1:0] port_mode;
    input [7:0] r;
    input [2:0] n;
    begin
      port_mode = {r[{n[1:0], 1'b1}], r[{n[1:0], 1'b0}]};
    end
  endfunction

  // Register file on the CPU bus.
  mode_reg_ahb u_regs (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .tristate_fuse_i (tristate_fuse_i),
    .hsel            (hsel_i),
    .haddr           (haddr_i),
    .htrans          (htrans_i),
    .hwrite          (hwrite_i),
    .hsize           (hsize_i),
    .hwdata          (hwdata_i),
    .hready          (hready_i),
    .hrdata          (hrdata_o),
    .hreadyout       (hreadyout_o),
    .hresp           (hresp_o),
    .mode_reg        (mode_reg)
  );

  // One driver per port; the fifth port is tied to quasi mode.
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      localparam [2:0] PORT_IDX = g;
      wire [1:0] mode_sel;
      wire [7:0] keep;
      assign mode_sel = (g == 4) ? `MODE_QUASI : port_mode(mode_reg, PORT_IDX);
      assign keep = (g == 3) ? `PWD_KEEP_P3 : ((g == 4) ? `PWD_KEEP_AUX : 8'h00);
      pin_driver u_drv (
        .clk_sys_i      (clk_sys_i),
        .reset_i        (reset_i),
        .mode_i         (mode_sel),
        .latch_i        (port_latch_i[g*8 +: 8]),
        .pin_sync_i     (pin_sync_reg[g*8 +: 8]),
        .keep_in_i      (keep),
        .power_down_i   (power_down_i),
        .pull_down_o    (pull_down_o[g*8 +: 8]),
        .strong_up_o    (strong_up_o[g*8 +: 8]),
        .weak_up_o      (weak_up_o[g*8 +: 8]),
        .very_weak_up_o (very_weak_up_o[g*8 +: 8]),
        .in_enable_o    (in_enable_o[g*8 +: 8])
      );
    end
  endgenerate

endmodule // port_mode_ctrl

// ### test/mode_checker.sv
// Assertions on the drive enables and bus answer of the port mode block.
`timescale 1ns/100ps
module mode_checker (
  input wire        clk_sys_i,
  input wire        reset_i,
  input wire        power_down_i,
  input wire [39:0] port_latch_i,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire [39:0] pull_down_o,
  input wire [39:0] strong_up_o,
  input wire [39:0] weak_up_o,
  input wire [39:0] very_weak_up_o,
  input wire [39:0] in_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Enables are registered, so checks look one edge back and skip the edge after reset.
  bus_ok_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ok");
  aux_sink_a: assert property (!port_latch_i[32] |=> pull_down_o[32]) else $error("aux sink");
  aux_vweak_a:
    assert property (!$past(reset_i) |-> very_weak_up_o[39:32] == $past(port_latch_i[39:32])) else $error("vweak");
  strong_one_a:
    assert property (!$past(reset_i) && $rose(port_latch_i[32]) |=> strong_up_o[32] ##1 !strong_up_o[32])
    else $error("strong pulse");
  weak_cause_a:
    assert property (!$past(reset_i) && weak_up_o[32] |-> $past(port_latch_i[32])) else $error("weak cause");
  pd_keep_a:
    assert property (!$past(reset_i) && $past(power_down_i) |-> in_enable_o == 40'hC00C000000) else $error("pd");
  in_on_a: assert property (!$past(reset_i) && !$past(power_down_i) |-> &in_enable_o) else $error("in off");
  no_fight_a:
    assert property ((pull_down_o & (strong_up_o | weak_up_o | very_weak_up_o)) == 40'h0) else $error("fight");
  cover property (power_down_i);
  cover property ($rose(port_latch_i[32]));
  cover property (|weak_up_o);
endmodule // mode_checker

bind port_mode_ctrl mode_checker chk (.clk_sys_i, .reset_i, .power_down_i, .port_latch_i, .hreadyout_o,
  .hresp_o, .pull_down_o, .strong_up_o, .weak_up_o, .very_weak_up_o, .in_enable_o);

// ### test/ext_pins.sv
// Model of the circuits on the far side of the port pins.
`timescale 1ns/100ps
module ext_pins (
  input  wire         clk_sys_i,
  input  wire  [39:0] ext_low_i,
  input  wire  [39:0] pull_down_i,
  input  wire  [39:0] up_any_i,
  output logic [39:0] pin_o
);
  logic [39:0] float_q = 40'h0;
  // An undriven pin has no keeper, so it wanders instead of keeping its level.
  always @(posedge clk_sys_i) float_q <= ~float_q;
  // An outside sink wins over every pull-up of the port.
  assign pin_o = ~(ext_low_i | pull_down_i) & (up_any_i | float_q);
endmodule // ext_pins

// ### test/tb_top.sv
// Self-checking bench for the port drive mode block with modelled pins.
`timescale 1ns/100ps
module tb_top;
  localparam logic [31:0] REG_ADDR = 32'h000000C1 * 4;
  localparam logic [39:0] AUX = 40'hFF00000000;
  logic        clk_sys_i = 1'b0, reset_i = 1'b1, fuse = 1'b0, pwd = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  what = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [39:0] latch = 40'h0, ext = 40'h0, lv, ev, e, pin, exp_q[$];
  logic [7:0]  m;
  wire  [31:0] hrdata;
  wire         hready;
  wire  [39:0] pd, su, wu, vu, ie;
  integer      seed = 60, n_fail = 0, checks = 0, i;
  // Free-running system clock.
  always #10 clk_sys_i = ~clk_sys_i;
  port_mode_ctrl dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .tristate_fuse_i(fuse), .power_down_i(pwd),
    .port_latch_i(latch), .pin_level_i(pin), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
    .pull_down_o(pd), .strong_up_o(su), .weak_up_o(wu), .very_weak_up_o(vu), .in_enable_o(ie));
  ext_pins far (.clk_sys_i(clk_sys_i), .ext_low_i(ext), .pull_down_i(pd), .up_any_i(su | wu | vu), .pin_o(pin));
  task automatic check(input string name, input logic [39:0] s, input logic [39:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, x, s);
    end
  endtask
  // Takes the oldest note whenever a result is flagged and compares it.
  always @(posedge clk_sys_i) if (what != 3'h0) begin
    e = exp_q.pop_front();
    case (what)
      3'h1: check("hrdata", {8'h0, hrdata}, e);
      3'h2: check("pull_down", pd, e);
      3'h3: check("strong_up", su, e);
      3'h4: check("weak_up", wu, e);
      3'h5: check("very_weak_up", vu, e);
      default: check("in_enable", ie, e);
    endcase
  end
  // Mask of the pins whose port is in mode c, coded high bit then low bit; the fifth port is always quasi.
  function automatic logic [39:0] pm(input logic [7:0] r, input logic [1:0] c);
    pm = (c == 2'h0) ? AUX : 40'h0;
    for (int n = 0; n < 4; n++) if (r[2*n +: 2] == c) pm[8*n +: 8] = 8'hFF;
  endfunction
  // One single word transfer; a read passes its expected value in d.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) exp_q.push_back({8'h0, d});
    what <= w ? 3'h0 : 3'h1;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    what <= 3'h0;
  endtask
  // Flags one output check of kind k against the value registered at the next edge.
  task automatic look(input logic [2:0] k, input logic [39:0] x);
    @(posedge clk_sys_i);
    exp_q.push_back(x);
    what <= k;
    @(posedge clk_sys_i);
    what <= 3'h0;
  endtask
  task automatic do_reset(input logic f);
    fuse <= f;
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence: reset value, every mode with random latches and outside sinks, power-down, fuse reset.
  initial begin
    do_reset(1'b0);
    bus(1'b0, REG_ADDR, 32'h03);
    bus(1'b0, REG_ADDR + 32'h4, 32'h0);
    for (i = 0; i < 8; i++) begin
      m = (i == 0) ? 8'h1B : (i == 1) ? 8'hE4 : 8'($random(seed));
      bus(1'b1, REG_ADDR, {24'h0, m});
      bus(1'b0, REG_ADDR, {24'h0, m});
      latch <= 40'h0;
      repeat (3) @(posedge clk_sys_i);
      lv = {8'($random(seed)), 32'($random(seed))};
      ev = {8'($random(seed)), 32'($random(seed))};
      latch <= lv;
      ext <= ev;
      look(3'h3, lv & (pm(m, 2'h0) | pm(m, 2'h2)));
      repeat (6) @(posedge clk_sys_i);
      look(3'h2, ~lv & ~pm(m, 2'h1));
      look(3'h3, lv & pm(m, 2'h2));
      look(3'h4, lv & pm(m, 2'h0) & ~ev);
      look(3'h5, lv & pm(m, 2'h0));
      look(3'h6, {40{1'b1}});
    end
    pwd <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    look(3'h6, 40'hC00C000000);
    pwd <= 1'b0;
    do_reset(1'b1);
    bus(1'b1, REG_ADDR + 32'h4, 32'hFF);
    bus(1'b0, REG_ADDR, 32'h55);
    look(3'h2, ~lv & AUX);
    look(3'h5, lv & AUX);
    final_report();
  end
  // Cuts a hang short; the sequence needs well under a tenth of this span.
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule // tb_top
